// [testbench/sfd_host.sv]
/*
 sfd_host: host controller model driving select, serial clock and data.
 Assumes: frame is called by the bench, one frame at a time.
*/
`timescale 1ns/1ps
module sfd_host (
    output logic       CS_N,
    output logic       SCK,
    output logic       SI,
    output logic [3:0] IO_IN
);
    // ============================================================
    // framing
    initial begin
        CS_N  = 1'b1;
        SCK   = 1'b0;
        SI    = 1'b0;
        IO_IN = 4'h0;
        // two idle clocks with select high settle the link state and mode sync
        repeat (2) begin
            #24 SCK = 1'b1;
            #24 SCK = 1'b0;
        end
    end

    // extra adds clocks after the opcode: 24 for three address bytes, or an odd count to break byte framing
    task automatic frame(input logic [7:0] op, input int extra, input logic quad);
        CS_N = 1'b0;
        #24;
        for (int i = 0; i < (quad ? 2 : 8) + extra; i++) begin
            if (quad)
                IO_IN = (i == 0) ? op[7:4] : op[3:0];
            else
                SI = (i < 8) ? op[7-i] : 1'b0;
            #24 SCK = 1'b1;
            #24 SCK = 1'b0;
        end
        // clock parked, select held long enough for the report
        #80 CS_N = 1'b1;
        SI    = ~SI;
        IO_IN = ~IO_IN;
        #150;
    endtask : frame
endmodule : sfd_host

// [testbench/sfd_top_sva.sv]
/*
 sfd_top_sva: timing and decode checks on the decoder top ports.
 Assumes: bound to sfd_top from the bench; one CLK domain watched.
*/
`timescale 1ns/1ps
module sfd_top_sva (
    input wire logic       CLK,
    input wire logic       SRST,
    input wire logic       NV_ADDR_DEFAULT,
    input wire logic       SOFT_RESET,
    input wire logic       CS_N,
    input wire logic       SO_OE,
    input wire logic [3:0] IO_OE,
    input wire logic       CMD_VALID,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic [2:0] CMD_ADDR_BYTES,
    input wire logic       CMD_END,
    input wire logic       CMD_ACCEPT,
    input wire logic       ADDR_LEN_32,
    input wire logic       QPI_MODE
);
    // ============================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_valid_one_cycle: assert property (CMD_VALID |=> !CMD_VALID)
        else $error("command valid held");
    a_end_one_cycle: assert property (CMD_END |=> !CMD_END)
        else $error("command end held");
    a_oe_drop_cs: assert property (CS_N && $past(CS_N) |-> !SO_OE && IO_OE == 4'h0)
        else $error("driving while deselected");
    a_quad_lines_mode: assert property (IO_OE != 4'h0 |-> QPI_MODE)
        else $error("shared lines driven outside quad mode");
    a_wide_four_bytes: assert property (CMD_VALID && CMD_OPCODE inside {8'h13, 8'h0c, 8'h3c, 8'h6c,
        8'hbc, 8'hec, 8'hee, 8'h12, 8'h34, 8'h21, 8'h53, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3} |-> CMD_ADDR_BYTES == 3'h4)
        else $error("wide opcode without four address bytes");
    a_follow_len: assert property (CMD_VALID && CMD_OPCODE inside {8'h5a, 8'h03, 8'h0b, 8'h3b, 8'h6b,
        8'hbb, 8'heb, 8'hed, 8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'h65, 8'h71, 8'h44, 8'h42, 8'h48,
        8'h3d, 8'h36, 8'h39, 8'hfb} |-> CMD_ADDR_BYTES == (ADDR_LEN_32 ? 3'h4 : 3'h3))
        else $error("legacy opcode address length wrong");
    a_no_addr: assert property (CMD_VALID && CMD_OPCODE inside {8'h9f, 8'haf, 8'h4b, 8'h05,
        8'h07, 8'h35, 8'h15, 8'h33} |-> CMD_ADDR_BYTES == 3'h0)
        else $error("register or ident read with address");
    a_len_reload: assert property ($fell(SRST) || $past(SOFT_RESET) |-> ADDR_LEN_32 == $past(NV_ADDR_DEFAULT))
        else $error("length bit not reloaded");
    a_quad_refuse: assert property (CMD_END && QPI_MODE && CMD_OPCODE inside {8'h07, 8'h35, 8'h15, 8'h33}
        |-> !CMD_ACCEPT)
        else $error("quad-unsupported read accepted");
endmodule : sfd_top_sva

// [testbench/tb_sfd_top.sv]
/*
 tb_sfd_top: self-checking bench for the command decoder.
 Assumes: sfd_host drives the link; reports are watched on CLK.
*/
`timescale 1ns/1ps
module tb_sfd_top;
    logic       CLK = 1'b0, SRST = 1'b1, NV_ADDR_DEFAULT = 1'b0, SOFT_RESET = 1'b0;
    logic       CS_N, SCK, SI, SO_OE, CMD_VALID, CMD_END, CMD_ACCEPT, ADDR_LEN_32, QPI_MODE;
    logic [3:0] IO_IN, IO_OE;
    logic [7:0] CMD_OPCODE, got_op;
    logic [2:0] CMD_ADDR_BYTES, got_bytes;
    logic       got_acc, so_seen, io_seen;
    int         n_mismatch = 0, n_checks = 0, n_valid, n_end;
    localparam logic [7:0] wide_ops [16] = '{8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec, 8'hee, 8'h12,
        8'h34, 8'h21, 8'h53, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3};
    localparam logic [7:0] follow_ops [22] = '{8'h5a, 8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'hed,
        8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'h65, 8'h71, 8'h44, 8'h42, 8'h48, 8'h3d, 8'h36, 8'h39, 8'hfb};
    localparam logic [7:0] plain_ops [8] = '{8'h9f, 8'haf, 8'h4b, 8'h05, 8'h07, 8'h35, 8'h15, 8'h33};

    always #5 CLK = ~CLK;

    sfd_top i_sfd_top (.CLK(CLK), .SRST(SRST), .NV_ADDR_DEFAULT(NV_ADDR_DEFAULT), .SOFT_RESET(SOFT_RESET),
        .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(), .SO_OE(SO_OE), .IO_IN(IO_IN), .IO_OUT(), .IO_OE(IO_OE),
        .CMD_VALID(CMD_VALID), .CMD_OPCODE(CMD_OPCODE), .CMD_ADDR_BYTES(CMD_ADDR_BYTES), .CMD_END(CMD_END),
        .CMD_ACCEPT(CMD_ACCEPT), .ADDR_LEN_32(ADDR_LEN_32), .QPI_MODE(QPI_MODE));
    sfd_host i_sfd_host (.CS_N(CS_N), .SCK(SCK), .SI(SI), .IO_IN(IO_IN));

    // ============================================================
    // report monitor
    always @(posedge CLK) begin
        if (CMD_VALID === 1'b1) begin
            n_valid++;
            got_op    = CMD_OPCODE;
            got_bytes = CMD_ADDR_BYTES;
        end
        if (CMD_END === 1'b1) begin
            n_end++;
            got_acc = CMD_ACCEPT;
        end
        if (SO_OE === 1'b1)
            so_seen = 1'b1;
        if (IO_OE === 4'hf)
            io_seen = 1'b1;
    end

    // ============================================================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] op, input int extra, input logic quad);
        n_valid = 0;
        n_end   = 0;
        so_seen = 1'b0;
        io_seen = 1'b0;
        @(posedge CLK) #2;
        i_sfd_host.frame(op, extra, quad);
        repeat (10) @(posedge CLK);
    endtask : cmd

    task automatic ok_cmd(input logic [7:0] op, input logic [2:0] nbytes, input logic quad);
        cmd(op, 0, quad);
        chk(8'(n_valid), 8'h01, "valid count");
        chk(got_op, op, "opcode");
        chk({5'h0, got_bytes}, {5'h0, nbytes}, "address bytes");
        chk({7'h0, got_acc}, 8'h01, "accept");
    endtask : ok_cmd

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // ============================================================
    // scenarios
    task automatic t_reset;
        chk({7'h0, ADDR_LEN_32}, 8'h00, "length after reset");
        NV_ADDR_DEFAULT = 1'b1;
        SOFT_RESET      = 1'b1;
        @(posedge CLK) #2 SOFT_RESET = 1'b0;
        @(posedge CLK) #2;
        chk({7'h0, ADDR_LEN_32}, 8'h01, "length after soft reset");
        NV_ADDR_DEFAULT = 1'b0;
        SRST            = 1'b1;
        repeat (2) @(posedge CLK);
        #2 SRST = 1'b0;
        @(posedge CLK) #2;
        chk({7'h0, ADDR_LEN_32}, 8'h00, "length after hard reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_tables;
        foreach (wide_ops[i]) ok_cmd(wide_ops[i], 3'h4, 1'b0);
        foreach (follow_ops[i]) ok_cmd(follow_ops[i], 3'h3, 1'b0);
        foreach (plain_ops[i]) ok_cmd(plain_ops[i], 3'h0, 1'b0);
        ok_cmd(8'hb7, 3'h0, 1'b0);
        chk({7'h0, ADDR_LEN_32}, 8'h01, "length set");
        foreach (follow_ops[i]) ok_cmd(follow_ops[i], 3'h4, 1'b0);
        ok_cmd(8'h13, 3'h4, 1'b0);
        ok_cmd(8'he9, 3'h0, 1'b0);
        $display("test tables done");
    endtask : t_tables

    task automatic t_link;
        cmd(8'h9f, 0, 1'b0);
        chk({7'h0, so_seen}, 8'h01, "read drives output");
        cmd(8'h02, 24, 1'b0);
        chk({7'h0, so_seen}, 8'h00, "write leaves output");
        cmd(8'h03, 24, 1'b0);
        chk({7'h0, so_seen}, 8'h01, "read after address");
        cmd(8'h9f, 3, 1'b0);
        chk({7'h0, got_acc}, 8'h00, "misaligned accept");
        cmd(8'h00, 0, 1'b0);
        chk(8'(n_valid + n_end), 8'h00, "unknown reported");
        $display("test link done");
    endtask : t_link

    task automatic t_quad;
        ok_cmd(8'h38, 3'h0, 1'b0);
        chk({7'h0, QPI_MODE}, 8'h01, "quad entered");
        // throwaway frame lets the mode reach the link
        cmd(8'h00, 0, 1'b1);
        cmd(8'h07, 0, 1'b1);
        chk({7'h0, got_acc}, 8'h00, "quad refused read");
        ok_cmd(8'h05, 3'h0, 1'b1);
        chk({6'h0, io_seen, so_seen}, 8'h02, "quad lines turn");
        ok_cmd(8'h9f, 3'h0, 1'b1);
        ok_cmd(8'hf5, 3'h0, 1'b1);
        chk({7'h0, QPI_MODE}, 8'h00, "quad left");
        $display("test quad done");
    endtask : t_quad

    initial begin
        repeat (16) @(posedge CLK);
        #2 SRST = 1'b0;
        repeat (2) @(posedge CLK);
        t_reset();
        t_tables();
        t_link();
        t_quad();
        results();
    end

    initial begin
        #500000;
        n_mismatch++;
        results();
    end
endmodule : tb_sfd_top

bind sfd_top sfd_top_sva i_sfd_top_sva (.CLK(CLK), .SRST(SRST), .NV_ADDR_DEFAULT(NV_ADDR_DEFAULT),
    .SOFT_RESET(SOFT_RESET), .CS_N(CS_N), .SO_OE(SO_OE), .IO_OE(IO_OE), .CMD_VALID(CMD_VALID),
    .CMD_OPCODE(CMD_OPCODE), .CMD_ADDR_BYTES(CMD_ADDR_BYTES), .CMD_END(CMD_END), .CMD_ACCEPT(CMD_ACCEPT),
    .ADDR_LEN_32(ADDR_LEN_32), .QPI_MODE(QPI_MODE));

// [verilog/sfd_decode.sv]
/*
 sfd_decode: maps an instruction byte onto its command class.
 Assumes: pure combinational use from either clock domain.
*/
`timescale 1ns/1ps
module sfd_decode (
    input  wire logic [7:0]         opcode,
    output sfd_pkg::sfd_class_t     cls
);
    // ==========================================================
    // class lookup
    always_comb begin
        cls = '{known: 1'b1, rd: 1'b0, follows: 1'b0, wide: 1'b0, qpi_ok: 1'b1};
        unique case (opcode)
            sfd_pkg::op_read_wide_addr, sfd_pkg::op_fast_read_wide_addr,
            sfd_pkg::op_dual_out_read_wide_addr, sfd_pkg::op_quad_out_read_wide_addr,
            sfd_pkg::op_dual_io_read_wide_addr, sfd_pkg::op_quad_io_read_wide_addr,
            sfd_pkg::op_ddr_quad_read_wide_addr, sfd_pkg::op_lock_state_read_wide_addr: begin
                cls.wide = 1'b1;
                cls.rd   = 1'b1;
                cls.qpi_ok = (opcode != sfd_pkg::op_read_wide_addr);
            end
            sfd_pkg::op_page_write_wide_addr, sfd_pkg::op_quad_page_write_wide_addr,
            sfd_pkg::op_sector_erase_wide_addr, sfd_pkg::op_half_block_erase_wide_addr,
            sfd_pkg::op_block_erase_wide_addr, sfd_pkg::op_lock_wide_addr,
            sfd_pkg::op_unlock_wide_addr, sfd_pkg::op_pointer_protect_wide_addr: begin
                cls.wide = 1'b1;
            end
            sfd_pkg::op_param_table_read, sfd_pkg::op_read, sfd_pkg::op_fast_read,
            sfd_pkg::op_dual_output_read, sfd_pkg::op_quad_output_read,
            sfd_pkg::op_dual_io_read, sfd_pkg::op_quad_io_read,
            sfd_pkg::op_ddr_quad_io_read, sfd_pkg::op_any_register_read,
            sfd_pkg::op_secure_region_read, sfd_pkg::op_lock_state_read: begin
                cls.follows = 1'b1;
                cls.rd      = 1'b1;
                cls.qpi_ok  = (opcode != sfd_pkg::op_read) && (opcode != sfd_pkg::op_fast_read);
            end
            sfd_pkg::op_page_write, sfd_pkg::op_quad_page_write, sfd_pkg::op_sector_erase,
            sfd_pkg::op_half_block_erase, sfd_pkg::op_block_erase,
            sfd_pkg::op_any_register_write, sfd_pkg::op_secure_region_erase,
            sfd_pkg::op_secure_region_write, sfd_pkg::op_block_lock,
            sfd_pkg::op_block_unlock, sfd_pkg::op_pointer_protect_set: begin
                cls.follows = 1'b1;
            end
            sfd_pkg::op_ident_read, sfd_pkg::op_quad_ident_read,
            sfd_pkg::op_unique_ident_read, sfd_pkg::op_status_one_read: begin
                cls.rd = 1'b1;
            end
            sfd_pkg::op_status_two_read, sfd_pkg::op_config_one_read,
            sfd_pkg::op_config_two_read, sfd_pkg::op_config_three_read: begin
                cls.rd     = 1'b1;
                cls.qpi_ok = 1'b0;
            end
            sfd_pkg::op_wide_addr_enter, sfd_pkg::op_wide_addr_exit,
            sfd_pkg::op_quad_mode_exit: begin
                cls.known = 1'b1;
            end
            sfd_pkg::op_quad_mode_enter: begin
                cls.qpi_ok = 1'b0;
            end
            default: begin
                cls.known  = 1'b0;
                cls.qpi_ok = 1'b0;
            end
        endcase
    end
endmodule : sfd_decode

// [verilog/sfd_pkg.sv]
/*
 sfd_pkg: opcodes, classes, sync depths and state records for the
 serial flash command decoder.
 Assumes: imported by nothing; every user writes sfd_pkg::name.
*/
package sfd_pkg;

    // ==========================================================
    // reads with a fixed four-byte address
    localparam logic [7:0] op_read_wide_addr          = 8'h13;
    localparam logic [7:0] op_fast_read_wide_addr     = 8'h0c;
    localparam logic [7:0] op_dual_out_read_wide_addr = 8'h3c;
    localparam logic [7:0] op_quad_out_read_wide_addr = 8'h6c;
    localparam logic [7:0] op_dual_io_read_wide_addr  = 8'hbc;
    localparam logic [7:0] op_quad_io_read_wide_addr  = 8'hec;
    localparam logic [7:0] op_ddr_quad_read_wide_addr = 8'hee;
    // ==========================================================
    // program, erase and lock with a fixed four-byte address
    localparam logic [7:0] op_page_write_wide_addr      = 8'h12;
    localparam logic [7:0] op_quad_page_write_wide_addr = 8'h34;
    localparam logic [7:0] op_sector_erase_wide_addr    = 8'h21;
    localparam logic [7:0] op_half_block_erase_wide_addr = 8'h53;
    localparam logic [7:0] op_block_erase_wide_addr     = 8'hdc;
    localparam logic [7:0] op_lock_state_read_wide_addr = 8'he0;
    localparam logic [7:0] op_lock_wide_addr            = 8'he1;
    localparam logic [7:0] op_unlock_wide_addr          = 8'he2;
    localparam logic [7:0] op_pointer_protect_wide_addr = 8'he3;
    // ==========================================================
    // address length follows the volatile setting
    localparam logic [7:0] op_param_table_read     = 8'h5a;
    localparam logic [7:0] op_read                 = 8'h03;
    localparam logic [7:0] op_fast_read            = 8'h0b;
    localparam logic [7:0] op_dual_output_read     = 8'h3b;
    localparam logic [7:0] op_quad_output_read     = 8'h6b;
    localparam logic [7:0] op_dual_io_read         = 8'hbb;
    localparam logic [7:0] op_quad_io_read         = 8'heb;
    localparam logic [7:0] op_ddr_quad_io_read     = 8'hed;
    localparam logic [7:0] op_page_write           = 8'h02;
    localparam logic [7:0] op_quad_page_write      = 8'h32;
    localparam logic [7:0] op_sector_erase         = 8'h20;
    localparam logic [7:0] op_half_block_erase     = 8'h52;
    localparam logic [7:0] op_block_erase          = 8'hd8;
    localparam logic [7:0] op_any_register_read    = 8'h65;
    localparam logic [7:0] op_any_register_write   = 8'h71;
    localparam logic [7:0] op_secure_region_erase  = 8'h44;
    localparam logic [7:0] op_secure_region_write  = 8'h42;
    localparam logic [7:0] op_secure_region_read   = 8'h48;
    localparam logic [7:0] op_lock_state_read      = 8'h3d;
    localparam logic [7:0] op_block_lock           = 8'h36;
    localparam logic [7:0] op_block_unlock         = 8'h39;
    localparam logic [7:0] op_pointer_protect_set  = 8'hfb;
    // ==========================================================
    // no address
    localparam logic [7:0] op_ident_read       = 8'h9f;
    localparam logic [7:0] op_quad_ident_read  = 8'haf;
    localparam logic [7:0] op_unique_ident_read = 8'h4b;
    localparam logic [7:0] op_status_one_read  = 8'h05;
    localparam logic [7:0] op_status_two_read  = 8'h07;
    localparam logic [7:0] op_config_one_read  = 8'h35;
    localparam logic [7:0] op_config_two_read  = 8'h15;
    localparam logic [7:0] op_config_three_read = 8'h33;
    localparam logic [7:0] op_wide_addr_enter  = 8'hb7;
    localparam logic [7:0] op_wide_addr_exit   = 8'he9;
    localparam logic [7:0] op_quad_mode_enter  = 8'h38;
    localparam logic [7:0] op_quad_mode_exit   = 8'hf5;

    // ==========================================================
    // counts and sizes
    localparam logic [2:0] addr_none   = 3'h0;
    localparam logic [2:0] addr_short  = 3'h3;
    localparam logic [2:0] addr_long   = 3'h4;
    localparam logic [2:0] bits_serial = 3'h1;
    localparam logic [2:0] bits_quad   = 3'h4;
    localparam logic [2:0] bytes_max   = 3'h7;
    localparam int         cs_stages   = 2;
    localparam int         stat_stages = 4;
    localparam int         mode_stages = 2;

    // ==========================================================
    // records
    typedef struct packed {
        logic known;
        logic rd;
        logic follows;
        logic wide;
        logic qpi_ok;
    } sfd_class_t;

    typedef struct packed {
        logic       done;
        logic       mis;
        logic [7:0] opcode;
    } sfd_stat_t;

    typedef struct packed {
        logic [2:0] bits;
        logic [2:0] nbytes;
        logic [7:0] shift;
        sfd_stat_t  st;
        logic       oe;
    } sfd_link_t;

    typedef enum logic [1:0] {
        ph_idle   = 2'b00,
        ph_opcode = 2'b01,
        ph_body   = 2'b11,
        ph_skip   = 2'b10
    } sfd_phase_t;

    typedef struct packed {
        sfd_phase_t phase;
        logic       addr4;
        logic       quad_peripheral_mode;
        sfd_stat_t  hold;
        sfd_class_t cls;
        logic       valid;
        logic       fin;
        logic       accept;
        logic [7:0] opcode;
        logic [2:0] abytes;
    } sfd_core_t;

endpackage : sfd_pkg

// [verilog/sfd_sync.sv]
/*
 sfd_sync: plain flip-flop chain for crossing levels and stable words.
 Assumes: the word is held steady long enough to be seen whole.
*/
`timescale 1ns/1ps
module sfd_sync #(
    parameter int W = 1,
    parameter int N = 2
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // ==========================================================
    // chain; first stage feeds only the second
    logic [N-1:0][W-1:0] chain;

    always_ff @(posedge clk) begin
        chain <= {chain[N-2:0], d};
    end

    assign q = chain[N-1];
endmodule : sfd_sync

// [verilog/sfd_top.sv]
/*
 sfd_top: command framing and opcode decode front end of a serial
 NOR flash. Link logic runs on the serial clock; command reporting
 and the volatile address-length and quad-mode bits run on CLK.
 Assumes: the host stops the serial clock at least a few CLK periods
 before raising select; the array, registers and read data live
 elsewhere, so data pins are driven low and only the enables matter.
*/
// Function
// - host drives select, clock, input; memory drives output only for read data.
// - in quad transfers host and memory take turns on shared lines.
// - select rising ends the current command.
// - select rising off a byte boundary rejects the command.
// - dedicated wide opcodes always take four address bytes.
// - recognise the seven wide-address read opcodes.
// - recognise the five wide-address program and erase opcodes.
// - recognise the four wide-address block-lock opcodes.
// - legacy opcodes take four address bytes when the length bit is set.
// - length bit reloads from its nonvolatile default on every reset.
// - legacy reads follow the length bit.
// - legacy program and erase follow the length bit.
// - parameter, register, security and lock opcodes follow the length bit.
// - identification reads take no address, serial or quad mode.
// - register reads take no address; only status one allowed in quad mode.
`timescale 1ns/1ps
module sfd_top (
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       NV_ADDR_DEFAULT,
    input  wire logic       SOFT_RESET,
    input  wire logic       SCK,
    input  wire logic       CS_N,
    input  wire logic       SI,
    output logic            SO,
    output logic            SO_OE,
    input  wire logic [3:0] IO_IN,
    output logic      [3:0] IO_OUT,
    output logic      [3:0] IO_OE,
    output logic            CMD_VALID,
    output logic      [7:0] CMD_OPCODE,
    output logic      [2:0] CMD_ADDR_BYTES,
    output logic            CMD_END,
    output logic            CMD_ACCEPT,
    output logic            ADDR_LEN_32,
    output logic            QPI_MODE
);

    // ==========================================================
    // declarations
    sfd_pkg::sfd_link_t  lk;
    sfd_pkg::sfd_link_t  next_lk;
    sfd_pkg::sfd_core_t  cr;
    sfd_pkg::sfd_core_t  next_cr;
    sfd_pkg::sfd_class_t lcls;
    sfd_pkg::sfd_class_t ccls;
    sfd_pkg::sfd_stat_t  stat_s;
    logic [1:0]          mode_l;
    logic                qpi_l;
    logic                addr4_l;
    logic                cs_s;
    logic [7:0]          lop;
    logic [7:0]          cop;
    logic [2:0]          linc;
    logic [7:0]          lsh;
    logic [2:0]          labytes;
    logic [2:0]          cabytes;

    // ==========================================================
    // crossings
    // mode bits only change between frames; the serial clock may
    // be idle then, so a frame starting right after a change may
    // still see the old value for its first two edges
    sfd_sync #(
        .W (2),
        .N (sfd_pkg::mode_stages)
    ) u_mode_sync (
        .clk (SCK),
        .d   ({cr.quad_peripheral_mode, cr.addr4}),
        .q   (mode_l)
    );
    assign qpi_l   = mode_l[1];
    assign addr4_l = mode_l[0];

    sfd_sync #(
        .W (1),
        .N (sfd_pkg::cs_stages)
    ) u_cs_sync (
        .clk (CLK),
        .d   (CS_N),
        .q   (cs_s)
    );

    // status runs deeper than select so the held copy is taken
    // before the frame-end clear of the link logic arrives
    sfd_sync #(
        .W ($bits(sfd_pkg::sfd_stat_t)),
        .N (sfd_pkg::stat_stages)
    ) u_stat_sync (
        .clk (CLK),
        .d   (lk.st),
        .q   (stat_s)
    );

    // ==========================================================
    // decoders, one per domain
    sfd_decode u_link_dec (
        .opcode (lop),
        .cls    (lcls)
    );

    sfd_decode u_core_dec (
        .opcode (cop),
        .cls    (ccls)
    );

    always_comb begin
        labytes = sfd_pkg::addr_none;
        if (lcls.wide) begin
            labytes = sfd_pkg::addr_long;
        end else if (lcls.follows) begin
            labytes = addr4_l ? sfd_pkg::addr_long : sfd_pkg::addr_short;
        end
    end

    always_comb begin
        cabytes = sfd_pkg::addr_none;
        if (ccls.wide) begin
            cabytes = sfd_pkg::addr_long;
        end else if (ccls.follows) begin
            cabytes = cr.addr4 ? sfd_pkg::addr_long : sfd_pkg::addr_short;
        end
    end

    // ==========================================================
    // link side, serial clock domain
    // shift in on the rising edge; one bit per edge, four in quad
    // mode. address phases of dual and quad io opcodes are still
    // counted as serial bits, a known simplification.
    assign linc = qpi_l ? sfd_pkg::bits_quad : sfd_pkg::bits_serial;
    assign lsh  = qpi_l ? {lk.shift[3:0], IO_IN} : {lk.shift[6:0], SI};
    assign lop  = lk.st.done ? lk.st.opcode : lsh;

    always_comb begin
        next_lk       = lk;
        next_lk.shift = lsh;
        next_lk.bits  = 3'(lk.bits + linc);
        next_lk.st.mis = (next_lk.bits != 3'h0);
        if (next_lk.bits == 3'h0) begin
            if (lk.nbytes != sfd_pkg::bytes_max) begin
                next_lk.nbytes = 3'(lk.nbytes + 3'h1);
            end
            if (!lk.st.done) begin
                next_lk.st.opcode = lsh;
                next_lk.st.done   = 1'b1;
            end
            // turn the lines round once opcode and address are in
            if (lcls.known && lcls.rd && (lcls.qpi_ok || !qpi_l)
                && (next_lk.nbytes > labytes)) begin
                next_lk.oe = 1'b1;
            end
        end
    end

    // select high clears the frame at once, even with no clock
    always_ff @(posedge SCK or posedge CS_N) begin
        if (CS_N) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // ==========================================================
    // pins; read data itself comes from outside this block
    assign SO     = 1'b0;
    assign IO_OUT = 4'h0;
    assign SO_OE  = lk.oe & ~qpi_l;
    assign IO_OE  = {4{lk.oe & qpi_l}};

    // ==========================================================
    // command side, CLK domain
    assign cop = (cr.phase == sfd_pkg::ph_body) ? cr.opcode : stat_s.opcode;

    always_comb begin
        next_cr        = cr;
        next_cr.valid  = 1'b0;
        next_cr.fin    = 1'b0;
        if (!cs_s) begin
            next_cr.hold = stat_s;
        end
        unique case (cr.phase)
            sfd_pkg::ph_idle: begin
                if (!cs_s) begin
                    next_cr.phase = sfd_pkg::ph_opcode;
                end
            end
            sfd_pkg::ph_opcode: begin
                if (cs_s) begin
                    next_cr.phase = sfd_pkg::ph_idle;
                // done and opcode flip on one serial edge, so one sample
                // may mix them; the held copy proves done was already seen
                end else if (stat_s.done && cr.hold.done) begin
                    if (ccls.known) begin
                        next_cr.phase  = sfd_pkg::ph_body;
                        next_cr.valid  = 1'b1;
                        next_cr.opcode = stat_s.opcode;
                        next_cr.abytes = cabytes;
                        next_cr.cls    = ccls;
                    end else begin
                        next_cr.phase = sfd_pkg::ph_skip;
                    end
                end
            end
            sfd_pkg::ph_body: begin
                if (cs_s) begin
                    next_cr.phase  = sfd_pkg::ph_idle;
                    next_cr.fin    = 1'b1;
                    // quad-unsupported commands in quad mode are refused
                    next_cr.accept = !cr.hold.mis && (!cr.quad_peripheral_mode || cr.cls.qpi_ok);
                    if (next_cr.accept) begin
                        unique case (cr.opcode)
                            sfd_pkg::op_wide_addr_enter: next_cr.addr4 = 1'b1;
                            sfd_pkg::op_wide_addr_exit:  next_cr.addr4 = 1'b0;
                            sfd_pkg::op_quad_mode_enter: next_cr.quad_peripheral_mode   = 1'b1;
                            sfd_pkg::op_quad_mode_exit:  next_cr.quad_peripheral_mode   = 1'b0;
                            default: begin
                                next_cr.quad_peripheral_mode = cr.quad_peripheral_mode;
                            end
                        endcase
                    end
                end
            end
            sfd_pkg::ph_skip: begin
                if (cs_s) begin
                    next_cr.phase = sfd_pkg::ph_idle;
                end
            end
        endcase
        if (SOFT_RESET) begin
            next_cr.addr4 = NV_ADDR_DEFAULT;
        end
        if (SRST) begin
            next_cr       = '0;
            next_cr.addr4 = NV_ADDR_DEFAULT;
        end
    end

    always_ff @(posedge CLK) begin
        cr <= next_cr;
    end

    // ==========================================================
    // outputs
    assign CMD_VALID      = cr.valid;
    assign CMD_OPCODE     = cr.opcode;
    assign CMD_ADDR_BYTES = cr.abytes;
    assign CMD_END        = cr.fin;
    assign CMD_ACCEPT     = cr.accept;
    assign ADDR_LEN_32    = cr.addr4;
    assign QPI_MODE       = cr.quad_peripheral_mode;

endmodule : sfd_top
